// >>> rtl/smc_defines.svh
// Offsets, field positions, reset values and wake timing of the sleep controller.
// Assumes inclusion by bare name; definitions only.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_ADDR_W          6
`define SMC_CTRL_ADDR       6'h33
`define SMC_CTRL_RESET      8'h00
`define SMC_SE_BIT          0
`define SMC_SM_LSB          1
`define SMC_SM_MSB          3
`define SMC_MODE_IDLE       3'h0
`define SMC_MODE_QUIET      3'h1
`define SMC_MODE_PDOWN      3'h2
`define SMC_MODE_PSAVE      3'h3
`define SMC_MODE_STANDBY    3'h6
`define SMC_HALT_CYCLES     16'h0004
`define SMC_STANDBY_CYCLES  16'h0006
`endif

// >>> rtl/smc_pkg.sv
// Types shared by the sleep controller.
// Assumes smc_defines.svh is available on the include path.
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_IDLE,
    SMC_QUIET,
    SMC_PDOWN,
    SMC_PSAVE,
    SMC_STANDBY,
    SMC_NONE
  } smc_mode_t;

  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_ASLEEP,
    SMC_START,
    SMC_HALT
  } smc_state_t;
endpackage

// >>> rtl/smc_sleep_ctrl.sv
// Sleep-mode controller: control register, clock domain gating and wake sequencing.
// Assumes wake sources from peripherals are on i_clk; the two pin inputs are asynchronous.
// Functional notes
// R1: Sleep starts only when sleep enable is set at the sleep instruction.
// R2: After wake, CPU halts four cycles beyond start-up, then runs the handler.
// R3: Register file and memory contents stay untouched across sleep and wake.
// R4: Reset during sleep wakes device and restarts at the reset vector.
// R5: Mode 000 Idle stops only CPU and flash clocks.
// R6: In Idle any enabled interrupt wakes the device.
// R7: Entering Idle or conversion quiet mode starts a conversion if converter enabled.
// R8: Mode 001 quiet mode stops I/O, CPU and flash clocks.
// R9: Quiet mode wakes only from its listed converter, serial, timer and pin sources.
// R10: In quiet mode timer and display wake only when running asynchronously.
// R11: Mode 010 Power-down stops main oscillator and all generated clocks. Here the main oscillator keeps running while i_osc_forced_on is set.
// R12: Power-down wakes only from reset, serial start, level interrupt zero, pin change.
// R13: Outside Idle, external interrupt zero wakes only as a level interrupt.
// R14: A level wake source must hold its level long enough to be seen.
// R15: Power-down wake waits the start-up delay chosen by the clock source fuses.
// R16: Mode 011 Power-save is Power-down plus the running asynchronous timer.
// R17: Power-save timer wake needs its interrupt enable and global enable.
// R18: Synchronous clock kept in Power-save reaches only the asynchronous timer.
// R19: Software uses Power-down instead of Power-save when the timer is off.
// R20: Mode 110 Standby is Power-down with the main oscillator running.
// R21: Wake-up from Standby completes in six clock cycles.
// R22: A reserved mode value makes the sleep instruction do nothing.
// R23: Clock gating enables change only while the gated clocks are low.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "smc_defines.svh"

module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic [`SMC_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  input  wire logic                  i_sleep_instr,
  input  wire logic [CNT_W-1:0]      i_startup_cycles,
  input  wire logic                  i_reset_req,
  input  wire logic                  i_external_interrupt_zero_pin_n,
  input  wire logic                  i_external_interrupt_zero_level_mode,
  input  wire logic                  i_external_interrupt_zero_en,
  input  wire logic                  i_pin_change,
  input  wire logic                  i_global_ie,
  input  wire logic                  i_other_irq,
  input  wire logic                  i_adc_enable,
  input  wire logic                  i_adc_done_irq,
  input  wire logic                  i_usi_start_irq,
  input  wire logic                  i_spm_ready_irq,
  input  wire logic                  i_lcd_irq,
  input  wire logic                  i_lcd_async,
  input  wire logic                  i_timer2_enabled,
  input  wire logic                  i_timer2_async,
  input  wire logic                  i_timer2_ovf,
  input  wire logic                  i_timer2_cmp,
  input  wire logic                  i_timer2_ovf_en,
  input  wire logic                  i_timer2_cmp_en,
  input  wire logic                  i_osc_forced_on,
  output logic                       o_cpu_clk_en,
  output logic                       o_flash_clk_en,
  output logic                       o_io_clk_en,
  output logic                       o_adc_clk_en,
  output logic                       o_asy_clk_en,
  output logic                       o_main_osc_en,
  output logic                       o_timer_osc_en,
  output logic                       o_timer2_clk_en,
  output logic                       o_adc_start,
  output logic                       o_wake_irq,
  output logic                       o_wake_reset,
  output logic                       o_sleeping
);

  // Pin inputs cross into i_clk through two flops each
  logic [1:0] external_interrupt_zero_sync_r;
  logic [1:0] pcint_sync_r;
  logic [1:0] external_interrupt_zero_sync_nxt;
  logic [1:0] pcint_sync_nxt;

  function automatic smc_mode_t decode_mode(input logic [2:0] sel);
    case (sel)
      `SMC_MODE_IDLE:    decode_mode = SMC_IDLE;    // R5
      `SMC_MODE_QUIET:   decode_mode = SMC_QUIET;   // R8
      `SMC_MODE_PDOWN:   decode_mode = SMC_PDOWN;   // R11
      `SMC_MODE_PSAVE:   decode_mode = SMC_PSAVE;   // R16
      `SMC_MODE_STANDBY: decode_mode = SMC_STANDBY; // R20
      default:           decode_mode = SMC_NONE;    // R22
    endcase
  endfunction

  logic [7:0]       ctrl_r;
  logic [7:0]       ctrl_nxt;
  logic [7:0]       rdata_r;
  logic [7:0]       rdata_nxt;
  smc_state_t       state_r;
  smc_state_t       state_nxt;
  smc_mode_t        mode_r;
  smc_mode_t        mode_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             adc_start_r;
  logic             adc_start_nxt;
  logic             wake_irq_r;
  logic             wake_irq_nxt;
  logic             wake_rst_r;
  logic             wake_rst_nxt;
  logic [7:0]       gate_r;
  logic [7:0]       gate_nxt;
  logic             sleeping_r;
  logic             sleeping_nxt;
  logic             external_interrupt_zero_lvl;
  logic             t2_wake;
  logic             wake_ok;
  smc_mode_t        sel_mode;

  assign sel_mode = decode_mode(ctrl_r[`SMC_SM_MSB:`SMC_SM_LSB]);
  assign external_interrupt_zero_lvl = i_external_interrupt_zero_en & ~external_interrupt_zero_sync_r[1];
  assign t2_wake  = i_global_ie & ((i_timer2_ovf & i_timer2_ovf_en) | (i_timer2_cmp & i_timer2_cmp_en)); // R17

  always_comb begin
    external_interrupt_zero_sync_nxt  = {external_interrupt_zero_sync_r[0], i_external_interrupt_zero_pin_n};
    pcint_sync_nxt = {pcint_sync_r[0], i_pin_change};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      external_interrupt_zero_sync_r  <= 2'h3;
      pcint_sync_r <= 2'h0;
    end else begin
      external_interrupt_zero_sync_r  <= external_interrupt_zero_sync_nxt;
      pcint_sync_r <= pcint_sync_nxt;
    end
  end

  // Wake sources allowed per mode
  always_comb begin
    wake_ok = 1'b0;
    case (mode_r)
      SMC_IDLE:  wake_ok = i_other_irq | external_interrupt_zero_lvl | pcint_sync_r[1] | i_usi_start_irq | i_lcd_irq | t2_wake
                         | i_spm_ready_irq | i_adc_done_irq; // R6
      SMC_QUIET: wake_ok = i_adc_done_irq | i_usi_start_irq | i_spm_ready_irq | pcint_sync_r[1]
                         | (external_interrupt_zero_lvl & i_external_interrupt_zero_level_mode)                          // R13
                         | (t2_wake & i_timer2_async) | (i_lcd_irq & i_lcd_async); // R9 R10
      SMC_PDOWN, SMC_STANDBY: wake_ok = i_usi_start_irq | pcint_sync_r[1] | (external_interrupt_zero_lvl & i_external_interrupt_zero_level_mode); // R12 R13
      SMC_PSAVE: wake_ok = i_usi_start_irq | pcint_sync_r[1] | (external_interrupt_zero_lvl & i_external_interrupt_zero_level_mode)
                         | (t2_wake & i_timer2_enabled) | (i_lcd_irq & i_lcd_async); // R16 R17
      default: wake_ok = 1'b0;
    endcase
  end

  // Register port, sequencer and pulses
  always_comb begin
    ctrl_nxt      = ctrl_r;
    rdata_nxt     = 8'h00;
    state_nxt     = state_r;
    mode_nxt      = mode_r;
    cnt_nxt       = cnt_r;
    adc_start_nxt = 1'b0;
    wake_irq_nxt  = 1'b0;
    wake_rst_nxt  = 1'b0;
    if (i_wr && i_addr == `SMC_CTRL_ADDR) begin
      ctrl_nxt = {4'h0, i_wdata[`SMC_SM_MSB:`SMC_SM_LSB], i_wdata[`SMC_SE_BIT]};
    end
    if (i_rd && i_addr == `SMC_CTRL_ADDR) begin
      rdata_nxt = ctrl_r;
    end
    case (state_r)
      SMC_RUN: begin
        if (i_sleep_instr && ctrl_r[`SMC_SE_BIT] && sel_mode != SMC_NONE) begin // R1 R22
          state_nxt     = SMC_ASLEEP;
          mode_nxt      = sel_mode;
          adc_start_nxt = i_adc_enable && (sel_mode == SMC_IDLE || sel_mode == SMC_QUIET); // R7
        end
      end
      SMC_ASLEEP: begin
        if (wake_ok) begin
          state_nxt = SMC_START;
          case (mode_r)
            SMC_PDOWN, SMC_PSAVE: cnt_nxt = i_startup_cycles;         // R15
            SMC_STANDBY:          cnt_nxt = CNT_W'(`SMC_STANDBY_CYCLES); // R21
            default:              cnt_nxt = '0;
          endcase
        end
      end
      SMC_START: begin
        if (cnt_r <= CNT_W'(1)) begin
          state_nxt = SMC_HALT;
          cnt_nxt   = CNT_W'(`SMC_HALT_CYCLES); // R2
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      SMC_HALT: begin
        if (cnt_r <= CNT_W'(1)) begin
          state_nxt    = SMC_RUN;
          wake_irq_nxt = 1'b1; // R2
          cnt_nxt      = '0;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      default: state_nxt = SMC_RUN;
    endcase
    // Reset request overrides any wake sequence in progress
    if (i_reset_req && state_r != SMC_RUN) begin // R4
      state_nxt    = SMC_RUN;
      wake_irq_nxt = 1'b0;
      wake_rst_nxt = 1'b1;
      cnt_nxt      = '0;
    end
  end

  // Gate vector, bit 7 down: timer osc, main osc, io, adc, asy, flash, cpu, timer2 clock.
  // Follows the next state so enables switch with it; no state is cleared, memory is kept.
  always_comb begin
    gate_nxt     = 8'hff;
    sleeping_nxt = (state_nxt != SMC_RUN);
    if (state_nxt == SMC_ASLEEP || state_nxt == SMC_START) begin // R3
      case (mode_nxt)
        SMC_IDLE:    gate_nxt = {i_timer2_async | i_lcd_async, 7'h79}; // R5
        SMC_QUIET:   gate_nxt = {i_timer2_async | i_lcd_async, 7'h58}; // R8 R10
        SMC_PSAVE:   gate_nxt = {i_timer2_enabled & i_timer2_async, i_osc_forced_on, 6'h08}
                              | {7'h00, i_osc_forced_on & i_timer2_enabled & ~i_timer2_async}; // R16 R18
        SMC_STANDBY: gate_nxt = 8'h40; // R20
        default:     gate_nxt = {1'b0, i_osc_forced_on, 6'h00}; // R11
      endcase
      // Oscillator must run while the start-up delay counts
      gate_nxt[6] = gate_nxt[6] | (state_nxt == SMC_START);
    end else if (state_nxt == SMC_HALT) begin
      gate_nxt = 8'h7d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r      <= `SMC_CTRL_RESET;
      rdata_r     <= 8'h00;
      state_r     <= SMC_RUN;
      mode_r      <= SMC_IDLE;
      cnt_r       <= '0;
      adc_start_r <= 1'b0;
      wake_irq_r  <= 1'b0;
      wake_rst_r  <= 1'b0;
      gate_r      <= 8'hff;
      sleeping_r  <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      rdata_r     <= rdata_nxt;
      state_r     <= state_nxt;
      mode_r      <= mode_nxt;
      cnt_r       <= cnt_nxt;
      adc_start_r <= adc_start_nxt;
      wake_irq_r  <= wake_irq_nxt;
      wake_rst_r  <= wake_rst_nxt;
      // Enables change just after the rising edge; the gate cells latch them in the low phase
      gate_r      <= gate_nxt; // R23
      sleeping_r  <= sleeping_nxt;
    end
  end

  assign o_rdata         = rdata_r;
  assign o_timer_osc_en  = gate_r[7];
  assign o_main_osc_en   = gate_r[6];
  assign o_io_clk_en     = gate_r[5];
  assign o_adc_clk_en    = gate_r[4];
  assign o_asy_clk_en    = gate_r[3];
  assign o_flash_clk_en  = gate_r[2];
  assign o_cpu_clk_en    = gate_r[1];
  assign o_timer2_clk_en = gate_r[0];
  assign o_adc_start     = adc_start_r;
  assign o_wake_irq      = wake_irq_r;
  assign o_wake_reset    = wake_rst_r;
  assign o_sleeping      = sleeping_r;

  // Checks
  int unsigned halt_len;
  always_ff @(posedge i_clk) begin
    if (i_rst || state_r != SMC_HALT) begin
      halt_len <= 0;
    end else begin
      halt_len <= halt_len + 1;
    end
  end

  property p_no_sleep_without_enable;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_RUN && i_sleep_instr && !ctrl_r[`SMC_SE_BIT]) |=> state_r == SMC_RUN;
  endproperty
  a_no_sleep_without_enable: assert property (p_no_sleep_without_enable) else $error("slept without enable"); // R1

  property p_reserved_mode;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_RUN && sel_mode == SMC_NONE) |=> state_r == SMC_RUN;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode entered sleep"); // R22

  property p_halt_four;
    @(posedge i_clk) disable iff (i_rst)
      ($rose(state_r == SMC_HALT) && !i_reset_req) ##1 (!i_reset_req)[*3] |-> ##1 (state_r == SMC_RUN && wake_irq_r);
  endproperty
  a_halt_four: assert property (p_halt_four) else $error("halt not four cycles"); // R2

  property p_halt_bound;
    @(posedge i_clk) disable iff (i_rst) halt_len <= 4;
  endproperty
  a_halt_bound: assert property (p_halt_bound) else $error("halt too long"); // R2

  property p_reset_wake;
    @(posedge i_clk) disable iff (i_rst)
      (state_r != SMC_RUN && i_reset_req) |=> (wake_rst_r && state_r == SMC_RUN && !wake_irq_r);
  endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("reset did not wake"); // R4

  property p_idle_clocks;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_ASLEEP && $past(state_r) == SMC_ASLEEP && mode_r == SMC_IDLE)
        |-> (!o_cpu_clk_en && !o_flash_clk_en && o_io_clk_en && o_adc_clk_en && o_main_osc_en);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle gating wrong"); // R5

  property p_quiet_clocks;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_ASLEEP && $past(state_r) == SMC_ASLEEP && mode_r == SMC_QUIET)
        |-> (!o_io_clk_en && o_adc_clk_en && o_asy_clk_en);
  endproperty
  a_quiet_clocks: assert property (p_quiet_clocks) else $error("quiet gating wrong"); // R8

  property p_pdown_osc_off;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_ASLEEP && $past(state_r) == SMC_ASLEEP && mode_r == SMC_PDOWN && !i_osc_forced_on)
        |-> (!o_main_osc_en && !o_io_clk_en && !o_adc_clk_en && !o_asy_clk_en);
  endproperty
  a_pdown_osc_off: assert property (p_pdown_osc_off) else $error("power-down clocks running"); // R11

  property p_pdown_edge_external_interrupt_zero;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_ASLEEP && mode_r == SMC_PDOWN && !i_external_interrupt_zero_level_mode && !i_usi_start_irq
       && !pcint_sync_r[1] && !i_reset_req) |=> state_r == SMC_ASLEEP;
  endproperty
  a_pdown_edge_external_interrupt_zero: assert property (p_pdown_edge_external_interrupt_zero) else $error("edge external_interrupt_zero woke power-down"); // R12 R13

  property p_standby_six;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_ASLEEP && mode_r == SMC_STANDBY && wake_ok && !i_reset_req)
        ##1 (!i_reset_req)[*6] |=> state_r == SMC_HALT;
  endproperty
  a_standby_six: assert property (p_standby_six) else $error("standby start-up not six"); // R21

  property p_adc_start;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SMC_RUN && i_sleep_instr && ctrl_r[`SMC_SE_BIT] && i_adc_enable && sel_mode == SMC_IDLE)
        |=> o_adc_start;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("no conversion start"); // R7

  c_idle_wake:    cover property (@(posedge i_clk) disable iff (i_rst) mode_r == SMC_IDLE && wake_irq_r);
  c_pdown_wake:   cover property (@(posedge i_clk) disable iff (i_rst) mode_r == SMC_PDOWN && wake_irq_r);
  c_psave_t2:     cover property (@(posedge i_clk) disable iff (i_rst) state_r == SMC_ASLEEP && mode_r == SMC_PSAVE && t2_wake);
  c_reset_wake:   cover property (@(posedge i_clk) disable iff (i_rst) wake_rst_r);

endmodule
`default_nettype wire

// >>> sim/smc_cpu_model.sv
// CPU-side partner: drives the register bus and issues the sleep instruction.
// Assumes the same clock as the sleep controller; all changes follow a rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "smc_defines.svh"

module smc_cpu_model (
  input  wire logic                   i_clk,
  input  wire logic [7:0]             i_rdata,
  input  wire logic                   i_sleeping,
  output logic      [`SMC_ADDR_W-1:0] o_addr,
  output logic      [7:0]             o_wdata,
  output logic                        o_wr,
  output logic                        o_rd,
  output logic                        o_sleep_instr
);
  initial begin
    o_addr = '0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_sleep_instr = 1'b0;
  end

  task automatic bus_wr(input logic [`SMC_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [`SMC_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1;
    d = i_rdata;
  endtask

  // A halted core fetches nothing, so no sleep is issued while asleep
  task automatic sleep_op();
    @(posedge i_clk);
    if (i_sleeping !== 1'b1) o_sleep_instr <= 1'b1;
    @(posedge i_clk);
    o_sleep_instr <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> sim/test_sleep_mode_controller.sv
// Self-checking bench of the sleep controller with a CPU partner model.
// Assumes 100 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "smc_defines.svh"

module test_sleep_mode_controller;
  import smc_pkg::*;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic [15:0]            startup = 16'h0003;
  logic                   rreq = 1'b0, external_interrupt_zero_n = 1'b1, external_interrupt_zero_lvl = 1'b0, external_interrupt_zero_en = 1'b0, pchg = 1'b0, gie = 1'b0;
  logic                   oirq = 1'b0, adc_en = 1'b0, adc_done = 1'b0, universal_serial_unit = 1'b0, spm = 1'b0, lcd = 1'b0;
  logic                   lcd_asy = 1'b0, t2_en = 1'b0, t2_asy = 1'b0, t2_ovf = 1'b0, t2_cmp = 1'b0;
  logic                   t2_ovf_en = 1'b0, t2_cmp_en = 1'b0, osc_on = 1'b0;
  wire logic [`SMC_ADDR_W-1:0] addr;
  wire logic [7:0]        wdata, rdata, en;
  wire logic              wr, rd, slp_i, adc_start, wake_irq, wake_rst, sleeping;
  int                     n_errors = 0;
  int                     comparisons = 0;
  logic [7:0]             d;

  always #5 clk = ~clk;

  smc_cpu_model smc_cpu_model_inst (.i_clk(clk), .i_rdata(rdata), .i_sleeping(sleeping), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_sleep_instr(slp_i));

  smc_sleep_ctrl #(.CNT_W(16)) smc_sleep_ctrl_inst (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sleep_instr(slp_i), .i_startup_cycles(startup),
    .i_reset_req(rreq), .i_external_interrupt_zero_pin_n(external_interrupt_zero_n), .i_external_interrupt_zero_level_mode(external_interrupt_zero_lvl), .i_external_interrupt_zero_en(external_interrupt_zero_en),
    .i_pin_change(pchg), .i_global_ie(gie), .i_other_irq(oirq), .i_adc_enable(adc_en),
    .i_adc_done_irq(adc_done), .i_usi_start_irq(universal_serial_unit), .i_spm_ready_irq(spm), .i_lcd_irq(lcd),
    .i_lcd_async(lcd_asy), .i_timer2_enabled(t2_en), .i_timer2_async(t2_asy), .i_timer2_ovf(t2_ovf),
    .i_timer2_cmp(t2_cmp), .i_timer2_ovf_en(t2_ovf_en), .i_timer2_cmp_en(t2_cmp_en),
    .i_osc_forced_on(osc_on), .o_cpu_clk_en(en[7]), .o_flash_clk_en(en[6]), .o_io_clk_en(en[5]),
    .o_adc_clk_en(en[4]), .o_asy_clk_en(en[3]), .o_main_osc_en(en[2]), .o_timer_osc_en(en[1]),
    .o_timer2_clk_en(en[0]), .o_adc_start(adc_start), .o_wake_irq(wake_irq), .o_wake_reset(wake_rst),
    .o_sleeping(sleeping));

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write mode with sleep enable set, sleep, check gating the cycle after
  task automatic enter(input logic [2:0] m, input logic [7:0] mask, input logic [7:0] e);
    smc_cpu_model_inst.bus_wr(`SMC_CTRL_ADDR, {4'h0, m, 1'b1});
    smc_cpu_model_inst.sleep_op();
    chk("sleeping", 16'h1, {15'h0, sleeping});
    chk("clock enables", {8'h0, e}, {8'h0, en & mask});
  endtask

  // Caller has just raised a source on an edge; edges are counted until wake
  task automatic wake_in(input int k_exp);
    int k;
    k = 0;
    while (wake_irq !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("wake latency", k_exp[15:0], k[15:0]);
    chk("cpu clock after wake", 16'h1, {15'h0, en[7]});
  endtask

  task automatic hold_asleep();
    repeat (15) @(posedge clk);
    #1;
    chk("still asleep", 16'h1, {15'h0, sleeping});
  endtask

  task automatic t_regs();
    chk("enables at reset", 16'h00ff, {8'h0, en});
    smc_cpu_model_inst.bus_rd(`SMC_CTRL_ADDR, d);
    chk("ctrl reset", {8'h0, `SMC_CTRL_RESET}, {8'h0, d});
    smc_cpu_model_inst.bus_wr(`SMC_CTRL_ADDR, 8'hf0);
    smc_cpu_model_inst.bus_wr(6'h10, 8'hff);
    smc_cpu_model_inst.bus_rd(6'h10, d);
    chk("unmapped read", 16'h0, {8'h0, d});
    smc_cpu_model_inst.bus_rd(`SMC_CTRL_ADDR, d);
    chk("ctrl upper bits", 16'h0, {8'h0, d});
  endtask

  task automatic t_refused();
    logic [2:0] m[4];
    m = '{3'h0, 3'h4, 3'h5, 3'h7};
    for (int i = 0; i < 4; i++) begin
      smc_cpu_model_inst.bus_wr(`SMC_CTRL_ADDR, {4'h0, m[i], i != 0});
      smc_cpu_model_inst.sleep_op();
      chk("no sleep", 16'h0, {15'h0, sleeping});
      chk("cpu clock kept", 16'h1, {15'h0, en[7]});
    end
  endtask

  task automatic t_idle();
    adc_en <= 1'b1;
    enter(`SMC_MODE_IDLE, 8'hfc, 8'h3c);
    chk("conversion start", 16'h1, {15'h0, adc_start});
    @(posedge clk);
    oirq <= 1'b1;
    wake_in(6);
    oirq <= 1'b0;
    smc_cpu_model_inst.bus_rd(`SMC_CTRL_ADDR, d);
    chk("ctrl kept", 16'h0001, {8'h0, d});
  endtask

  task automatic t_quiet();
    enter(`SMC_MODE_QUIET, 8'hfc, 8'h1c);
    chk("conversion start", 16'h1, {15'h0, adc_start});
    @(posedge clk);
    oirq <= 1'b1;
    external_interrupt_zero_en <= 1'b1;
    external_interrupt_zero_n <= 1'b0;
    lcd <= 1'b1;
    hold_asleep();
    oirq <= 1'b0;
    external_interrupt_zero_n <= 1'b1;
    lcd <= 1'b0;
    @(posedge clk);
    adc_done <= 1'b1;
    wake_in(6);
    adc_done <= 1'b0;
  endtask

  task automatic t_pdown();
    adc_en <= 1'b0;
    enter(`SMC_MODE_PDOWN, 8'hff, 8'h00);
    @(posedge clk);
    oirq <= 1'b1;
    adc_done <= 1'b1;
    hold_asleep();
    oirq <= 1'b0;
    adc_done <= 1'b0;
    external_interrupt_zero_lvl <= 1'b1;
    @(posedge clk);
    external_interrupt_zero_n <= 1'b0;
    wake_in(10);
    external_interrupt_zero_n <= 1'b1;
  endtask

  task automatic t_psave();
    t2_en <= 1'b1;
    t2_asy <= 1'b1;
    t2_ovf_en <= 1'b1;
    enter(`SMC_MODE_PSAVE, 8'hfd, 8'h08);
    @(posedge clk);
    t2_ovf <= 1'b1;
    hold_asleep();
    gie <= 1'b1;
    wake_in(8);
    t2_ovf <= 1'b0;
    t2_asy <= 1'b0;
    osc_on <= 1'b1;
    enter(`SMC_MODE_PSAVE, 8'hf1, 8'h01);
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset wake", 16'h1, {15'h0, wake_rst});
    chk("no irq wake", 16'h0, {15'h0, wake_irq});
    rreq <= 1'b0;
    @(posedge clk);
    #1;
    chk("enables after reset wake", 16'h00ff, {8'h0, en});
  endtask

  task automatic t_standby();
    osc_on <= 1'b0;
    t2_en <= 1'b0;
    enter(`SMC_MODE_STANDBY, 8'hff, 8'h04);
    @(posedge clk);
    universal_serial_unit <= 1'b1;
    wake_in(`SMC_STANDBY_CYCLES + 5);
    universal_serial_unit <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_regs();
    t_refused();
    t_idle();
    t_quiet();
    t_pdown();
    t_psave();
    t_standby();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
